// ### dma_req_pkg.sv
// Package with register map, field layout, channel count and widths of the DMA channel control block.
package dma_req_pkg;
	// Channel count and widths.
	localparam int NUM_CH_DEF = 4;
	localparam int ADDR_W     = 24;
	localparam int CNT_W      = 16;
	// Per-channel register block: stride and word offsets within it.
	localparam logic [11:0] CH_STRIDE    = 12'h040;
	localparam logic [11:0] OFF_CAUSE    = 12'h000;
	localparam logic [11:0] OFF_MODE     = 12'h004;
	localparam logic [11:0] OFF_PERIPH   = 12'h008;
	localparam logic [11:0] OFF_MEM      = 12'h00c;
	localparam logic [11:0] OFF_MEM_RLD  = 12'h010;
	localparam logic [11:0] OFF_CNT      = 12'h014;
	localparam logic [11:0] OFF_CNT_RLD  = 12'h018;
	localparam logic [11:0] OFF_STATUS   = 12'h01c;
	// Cause-select register fields.
	localparam int CAUSE_REQ_BIT = 7;
	localparam int CAUSE_SW_BIT  = 5;
	localparam int CAUSE_SEL_W   = 5;
	localparam int CAUSE_SEL_LSB = 0;
	localparam logic [7:0] CAUSE_RST = 8'h00;
	// Cause code for the software trigger and for the first timer.
	localparam logic [4:0] SEL_SOFTWARE = 5'h00;
	localparam logic [4:0] SEL_TIMER0   = 5'h03;
	// Transfer-mode field of the mode register.
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	// Status register bit positions.
	localparam int ST_ACTIVE = 0;
	localparam int ST_DONE   = 1;
	localparam int ST_DROP   = 2;
	// Number of cause inputs per channel.
	localparam int NUM_CAUSE = 32;
endpackage : dma_req_pkg

// ### dma_req_chan.sv
// One DMA channel: request flag, auto-clear, transfer count and reload.
`timescale 1ns/1ns
`default_nettype none
module dma_req_chan
	import dma_req_pkg::*;
(
	input  wire logic                 pclk,       // Clock.
	input  wire logic                 presetn,    // Async reset, low.
	input  wire logic                 cause_we,   // Cause register write.
	input  wire logic [7:0]           cause_wd,   // Cause write data.
	input  wire logic                 mode_we,    // Mode register write.
	input  wire logic [1:0]           mode_wd,    // Mode write data.
	input  wire logic                 reg_we,     // Address/count write.
	input  wire logic [2:0]           reg_sel,    // Which one is written.
	input  wire logic [31:0]          reg_wd,     // Address/count data.
	input  wire logic [NUM_CAUSE-1:0] cause_in,   // Peripheral request pulses.
	output logic      [7:0]           cause_r,    // Cause register.
	output logic      [1:0]           mode_r,     // Mode register.
	output logic      [ADDR_W-1:0]    periph_r,   // Peripheral address.
	output logic      [ADDR_W-1:0]    mem_r,      // Memory address.
	output logic      [ADDR_W-1:0]    mem_rld_r,  // Memory reload.
	output logic      [CNT_W-1:0]     cnt_r,      // Transfer count.
	output logic      [CNT_W-1:0]     cnt_rld_r,  // Count reload.
	output logic                      xfer_r,     // One transfer pulse.
	output logic                      done_r,     // Sticky completion.
	output logic                      drop_r      // Sticky dropped request.
);
	logic [4:0] sel;      // Selected cause.
	logic       hw_req;   // Peripheral request on selected cause.
	logic       pend;     // Request flag currently set.
	logic       live;     // Channel may transfer.
	logic       take;     // A transfer happens now.
	logic       reject;   // Request dropped: channel off or count zero.

	assign sel    = cause_r[CAUSE_SEL_LSB +: CAUSE_SEL_W];
	assign hw_req = cause_in[sel];
	assign pend   = cause_r[CAUSE_REQ_BIT];
	assign live   = (mode_r != MODE_OFF) && (cnt_r != '0);
	assign take   = pend && live && !cause_we;
	assign reject = pend && !live && !cause_we;

	// Cause register; the request flag is set by peripheral or write, cleared
	// only here. A peripheral request beats the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_r <= CAUSE_RST;
		end else if (cause_we) begin
			cause_r <= cause_wd;
		end else if (hw_req) begin
			cause_r[CAUSE_REQ_BIT] <= 1'b1;
		end else if (take || reject) begin
			cause_r[CAUSE_REQ_BIT] <= 1'b0;
			cause_r[CAUSE_SW_BIT]  <= 1'b0;
		end
	end

	// Mode register, written by software, cleared on completion.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= MODE_OFF;
		end else if (mode_we) begin
			mode_r <= mode_wd;
		end else if (take && cnt_r == CNT_W'(1)) begin
			mode_r <= MODE_OFF;
		end
	end

	// Address and count registers with reload.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_r  <= '0;
			mem_r     <= '0;
			mem_rld_r <= '0;
			cnt_r     <= '0;
			cnt_rld_r <= '0;
		end else if (reg_we) begin
			case (reg_sel)
				3'h0: periph_r  <= reg_wd[ADDR_W-1:0];
				3'h1: mem_r     <= reg_wd[ADDR_W-1:0];
				3'h2: mem_rld_r <= reg_wd[ADDR_W-1:0];
				3'h3: cnt_r     <= reg_wd[CNT_W-1:0];
				3'h4: cnt_rld_r <= reg_wd[CNT_W-1:0];
				default: ;
			endcase
		end else if (take) begin
			if (cnt_r == CNT_W'(1)) begin
				cnt_r <= cnt_rld_r;
				mem_r <= mem_rld_r;
			end else begin
				cnt_r <= cnt_r - CNT_W'(1);
				mem_r <= mem_r + ADDR_W'(1);
			end
		end
	end

	// Event outputs: transfer pulse, sticky done and drop flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_r <= 1'b0;
			done_r <= 1'b0;
			drop_r <= 1'b0;
		end else begin
			xfer_r <= take;
			// Set wins over the clear done by a mode write.
			done_r <= (take && cnt_r == CNT_W'(1)) || (done_r && !mode_we);
			drop_r <= reject || (drop_r && !mode_we);
		end
	end

	property p_no_xfer_off;
		@(posedge pclk) disable iff (!presetn)
		(pend && mode_r == MODE_OFF && !cause_we && !hw_req)
		|=> !xfer_r && !pend;
	endproperty
	a_no_xfer_off: assert property (p_no_xfer_off)
		else $error("Transfer or flag kept on disabled channel.");

	property p_zero_cnt;
		@(posedge pclk) disable iff (!presetn)
		(pend && cnt_r == '0 && !cause_we && !hw_req) |=> !pend && drop_r;
	endproperty
	a_zero_cnt: assert property (p_zero_cnt)
		else $error("Zero count request not dropped.");

	property p_dec;
		@(posedge pclk) disable iff (!presetn)
		(take && !reg_we && cnt_r > CNT_W'(1)) |=>
			xfer_r && cnt_r == $past(cnt_r) - CNT_W'(1);
	endproperty
	a_dec: assert property (p_dec)
		else $error("Count not decremented on transfer.");

	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		(take && !reg_we && !mode_we && cnt_r == CNT_W'(1)) |=>
			cnt_r == $past(cnt_rld_r) && mode_r == MODE_OFF && done_r;
	endproperty
	a_reload: assert property (p_reload)
		else $error("Reload or stop missing at count end.");

	property p_flag_bit;
		@(posedge pclk) disable iff (!presetn)
		cause_we |=> cause_r[CAUSE_REQ_BIT] == $past(cause_wd[7]);
	endproperty
	a_flag_bit: assert property (p_flag_bit)
		else $error("Request flag not at bit 7.");

	c_xfer: cover property (@(posedge pclk) disable iff (!presetn) take);
	c_drop: cover property (@(posedge pclk) disable iff (!presetn) reject);
	c_done: cover property (@(posedge pclk) disable iff (!presetn)
		take && cnt_r == CNT_W'(1));
endmodule : dma_req_chan
`default_nettype wire

// ### dma_req_ctrl.sv
// APB register front end and channel array of the DMA request controller.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// The block sits behind an APB slave port. Software reaches a bank of
// channels, each with a cause register that holds the request flag, a
// transfer-mode register, address and count registers with reloads
// and a read-only status word. A channel turns a pending request into
// one transfer pulse while it is enabled and its count is not zero.
// Any other pending request is dropped and its flag is cleared by the
// hardware, so software never has to clear it. When the count runs out
// the channel reloads and disables itself until it is set up again.
// The settling time between a cause write and the enable is the duty
// of the driver software: the hardware takes the enable at once and
// does not measure that time.
// All writes land at the edge that completes the bus transfer.
// Function
// - Request on idle channel: no transfer, flag cleared
// - Request flag lives at bit 7
// - Mode 00 disables the channel
// - Mode 01 enables single transfer
// - Pattern 10000011b selects timer with flag
module dma_req_ctrl
	import dma_req_pkg::*;
#(
	parameter int NUM_CH = NUM_CH_DEF  // Number of channels.
)(
	input  wire logic                        pclk,     // Clock, 250 MHz.
	input  wire logic                        presetn,  // Async reset, low.
	input  wire logic                        psel,     // APB select.
	input  wire logic                        penable,  // APB access phase.
	input  wire logic                        pwrite,   // APB direction.
	input  wire logic [11:0]                 paddr,    // APB byte address.
	input  wire logic [31:0]                 pwdata,   // APB write data.
	output logic      [31:0]                 prdata,   // APB read data.
	output logic                             pready,   // APB ready.
	output logic                             pslverr,  // APB error.
	input  wire logic [NUM_CH*NUM_CAUSE-1:0] cause_in, // Request inputs.
	output logic      [NUM_CH-1:0]           xfer_o,   // Transfer pulses.
	output logic      [NUM_CH*ADDR_W-1:0]    src_o,    // Peripheral addr.
	output logic      [NUM_CH*ADDR_W-1:0]    dst_o     // Memory address.
);
	// Width of the channel index taken from the address; a single
	// channel still needs one bit so that the index select stays legal.
	localparam int CHW = $clog2(NUM_CH) > 0 ? $clog2(NUM_CH) : 1;

	// Decoded bus state for the addressed register.
	logic            setup;  // APB setup phase seen.
	logic            acc;    // APB access phase ending.
	logic [CHW-1:0]  ch;     // Channel index from address.
	logic [11:0]     off;    // Offset within channel block.
	logic            hit;    // Address maps to a register.
	logic [31:0]     rd_nxt; // Read data next value.

	// Register images of every channel, fed back from the instances.
	logic [7:0]        cause_v  [NUM_CH]; // Per-channel cause.
	logic [1:0]        mode_v   [NUM_CH]; // Per-channel mode.
	logic [ADDR_W-1:0] per_v    [NUM_CH]; // Peripheral addr.
	logic [ADDR_W-1:0] mem_v    [NUM_CH]; // Memory addr.
	logic [ADDR_W-1:0] mrld_v   [NUM_CH]; // Memory reload.
	logic [CNT_W-1:0]  cnt_v    [NUM_CH]; // Count.
	logic [CNT_W-1:0]  crld_v   [NUM_CH]; // Count reload.
	logic [NUM_CH-1:0] xfer_v;            // Transfer pulses.
	logic [NUM_CH-1:0] done_v;            // Done flags.
	logic [NUM_CH-1:0] drop_v;            // Drop flags.

	// Address decode: channel blocks of CH_STRIDE bytes. Register writes
	// wait for the access phase, the edge at which the master samples
	// pready high, so a write never lands before the transfer completes.
	// Unaligned or out-of-range offsets fall outside every register.
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready;
	assign ch    = CHW'(paddr / CH_STRIDE);
	assign off   = paddr % CH_STRIDE;
	assign hit   = (paddr / CH_STRIDE) < 12'(NUM_CH) && off <= OFF_STATUS
		&& off[1:0] == 2'b00;

	// Zero-wait-state slave: ready in the access phase after setup.
	// pready is a registered copy of the setup decode, so it stands for
	// exactly the one access cycle; pslverr rides along with it for an
	// address that maps to no register.
	// The slave never stretches a transfer, which keeps software
	// polling loops short and their timing fixed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit;
		end
	end

	// Read multiplexer for the addressed register. Narrow fields sit in
	// the low bits and every unused bit reads zero; the status word is
	// built from the mode field and the sticky flags of the channel.
	always_comb begin
		rd_nxt = '0;
		if (hit) begin
			case (off)
				OFF_CAUSE:   rd_nxt = 32'(cause_v[ch]);
				OFF_MODE:    rd_nxt = 32'(mode_v[ch]);
				OFF_PERIPH:  rd_nxt = 32'(per_v[ch]);
				OFF_MEM:     rd_nxt = 32'(mem_v[ch]);
				OFF_MEM_RLD: rd_nxt = 32'(mrld_v[ch]);
				OFF_CNT:     rd_nxt = 32'(cnt_v[ch]);
				OFF_CNT_RLD: rd_nxt = 32'(crld_v[ch]);
				// Active mirrors the mode field; the rest are sticky.
				OFF_STATUS: begin
					rd_nxt[ST_ACTIVE] = mode_v[ch] != MODE_OFF;
					rd_nxt[ST_DONE]   = done_v[ch];
					rd_nxt[ST_DROP]   = drop_v[ch];
				end
				default: rd_nxt = '0;
			endcase
		end
	end

	// Read data is captured in the setup cycle and shown with pready.
	// It holds until the next read. Capturing one cycle early costs
	// nothing, as every register here is a plain flip-flop with no side
	// effect on reading.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			prdata <= rd_nxt;
		end
	end

	// Per-channel instances; writes land at the end of the access phase.
	// Each channel decodes its own write strobes from the shared offset,
	// so the cause, mode and address/count writes of one transfer can
	// never reach two channels at once.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			logic wsel;  // Write to this channel.
			assign wsel = acc && pwrite && hit && ch == CHW'(g);
			dma_req_chan u_chan (
				.pclk      (pclk),
				.presetn   (presetn),
				.cause_we  (wsel && off == OFF_CAUSE),
				.cause_wd  (pwdata[7:0]),
				.mode_we   (wsel && off == OFF_MODE),
				.mode_wd   (pwdata[1:0]),
				.reg_we    (wsel && off >= OFF_PERIPH && off <= OFF_CNT_RLD),
				.reg_sel   (3'((off - OFF_PERIPH) >> 2)),
				.reg_wd    (pwdata),
				.cause_in  (cause_in[g*NUM_CAUSE +: NUM_CAUSE]),
				.cause_r   (cause_v[g]),
				.mode_r    (mode_v[g]),
				.periph_r  (per_v[g]),
				.mem_r     (mem_v[g]),
				.mem_rld_r (mrld_v[g]),
				.cnt_r     (cnt_v[g]),
				.cnt_rld_r (crld_v[g]),
				.xfer_r    (xfer_v[g]),
				.done_r    (done_v[g]),
				.drop_r    (drop_v[g])
			);
		end
	endgenerate

	// Transfer outputs registered once more so they leave from flip-flops.
	// This adds one cycle of latency to every pulse and address, which
	// the far side must allow for; in return no output carries a decode
	// path from the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_o <= '0;
			src_o  <= '0;
			dst_o  <= '0;
		end else begin
			xfer_o <= xfer_v;
			for (int i = 0; i < NUM_CH; i++) begin
				src_o[i*ADDR_W +: ADDR_W] <= per_v[i];
				dst_o[i*ADDR_W +: ADDR_W] <= mem_v[i];
			end
		end
	end

	// Bus-side checks: every write is judged at the edge that completes
	// it, and the channel is the one addressed by that transfer, since
	// the master may move the address right after it.
	// timer pattern sets flag
	property p_timer_sel;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_CAUSE
			&& pwdata[7:0] == {1'b1, 2'b00, SEL_TIMER0})
		|=> cause_v[$past(ch)] == {1'b1, 2'b00, SEL_TIMER0};
	endproperty
	a_timer_sel: assert property (p_timer_sel)
		else $error("Timer cause pattern not stored.");

	property p_mode_off;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_MODE
			&& pwdata[1:0] == MODE_OFF) |=> ##2 !xfer_o[$past(ch, 3)];
	endproperty
	a_mode_off: assert property (p_mode_off)
		else $error("Transfer after channel disabled.");

	property p_mode_single;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_MODE
			&& pwdata[1:0] == MODE_SINGLE)
		|=> mode_v[$past(ch)] == MODE_SINGLE;
	endproperty
	a_mode_single: assert property (p_mode_single)
		else $error("Single mode not entered.");

	property p_ready;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("APB ready not one cycle after setup.");

	property p_no_rdy;
		@(posedge pclk) disable iff (!presetn)
		!setup |=> !pready;
	endproperty
	a_no_rdy: assert property (p_no_rdy)
		else $error("APB ready without a setup cycle.");

	property p_err;
		@(posedge pclk) disable iff (!presetn)
		(setup && !hit) |=> pready && pslverr;
	endproperty
	a_err: assert property (p_err)
		else $error("No error answer for unmapped address.");

	property p_err_rd;
		@(posedge pclk) disable iff (!presetn)
		(setup && !hit && !pwrite) |=> prdata == '0;
	endproperty
	a_err_rd: assert property (p_err_rd)
		else $error("Unmapped read returned data.");

	property p_cause_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_CAUSE)
		|=> cause_v[$past(ch)] == $past(pwdata[7:0]);
	endproperty
	a_cause_wr: assert property (p_cause_wr)
		else $error("Cause write not stored.");

	property p_per_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_PERIPH)
		|=> per_v[$past(ch)] == $past(pwdata[ADDR_W-1:0]);
	endproperty
	a_per_wr: assert property (p_per_wr)
		else $error("Peripheral address write not stored.");

	property p_mem_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_MEM)
		|=> mem_v[$past(ch)] == $past(pwdata[ADDR_W-1:0]);
	endproperty
	a_mem_wr: assert property (p_mem_wr)
		else $error("Memory address write not stored.");

	property p_mrld_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_MEM_RLD)
		|=> mrld_v[$past(ch)] == $past(pwdata[ADDR_W-1:0]);
	endproperty
	a_mrld_wr: assert property (p_mrld_wr)
		else $error("Memory reload write not stored.");

	property p_cnt_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_CNT)
		|=> cnt_v[$past(ch)] == $past(pwdata[CNT_W-1:0]);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr)
		else $error("Count write not stored.");

	property p_crld_wr;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && off == OFF_CNT_RLD)
		|=> crld_v[$past(ch)] == $past(pwdata[CNT_W-1:0]);
	endproperty
	a_crld_wr: assert property (p_crld_wr)
		else $error("Count reload write not stored.");

	// Cover points: a completed write and an error answer.
	c_write: cover property (@(posedge pclk) disable iff (!presetn)
		pready && pwrite);
	c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule : dma_req_ctrl
`default_nettype wire

// ### dma_req_periph_model.sv
// Peripheral model that raises periodic request pulses on one cause line.
`timescale 1ns/1ns
`default_nettype none
module dma_req_periph_model
	import dma_req_pkg::*;
#(
	parameter int NUM_CH = NUM_CH_DEF, // Number of channels.
	parameter int PERIOD = 8           // Cycles between two requests.
)(
	input  wire logic                        pclk,    // Clock.
	input  wire logic                        presetn, // Async reset, low.
	input  wire logic                        run,     // Peripheral enabled.
	input  wire logic [7:0]                  line,    // Request line index.
	output logic      [NUM_CH*NUM_CAUSE-1:0] req_o    // Request lines.
);
	int unsigned tick; // Cycles since the last request.

	// Pulses one cycle every PERIOD cycles while enabled.
	// quiet while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick  <= 0;
			req_o <= '0;
		end else begin
			req_o <= '0;
			if (run && tick == PERIOD - 1) begin
				req_o[line] <= 1'b1;
			end
			tick <= run ? (tick + 1) % PERIOD : 0;
		end
	end
endmodule : dma_req_periph_model
`default_nettype wire

// ### test_dma_request_channel_control.sv
// Self-checking bench of the DMA request channel controller.
`timescale 1ns/1ns
`default_nettype none
module test_dma_request_channel_control;
	import dma_req_pkg::*;
	localparam int NCH = NUM_CH_DEF; // Channels in the design.
	logic                     pclk, presetn, psel, penable, pwrite;
	logic                     pready, pslverr, run, err;
	logic [11:0]              paddr;
	logic [31:0]              pwdata, prdata, rd;
	logic [7:0]               line;
	logic [NCH*NUM_CAUSE-1:0] cause_in;
	logic [NCH-1:0]           xfer_o;
	logic [NCH*ADDR_W-1:0]    src_o, dst_o;
	int                       fails, n_compared, cycles;
	int                       xcnt [NCH]; // Transfer pulses per channel.
	logic [11:0] offs [5] = '{OFF_PERIPH, OFF_MEM, OFF_MEM_RLD, OFF_CNT,
		OFF_CNT_RLD};
	logic [31:0] msk [5] = '{32'h00ffffff, 32'h00ffffff, 32'h00ffffff,
		32'h0000ffff, 32'h0000ffff};

	dma_req_ctrl #(.NUM_CH(NCH)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cause_in(cause_in), .xfer_o(xfer_o),
		.src_o(src_o), .dst_o(dst_o));
	dma_req_periph_model #(.NUM_CH(NCH)) u_periph (.pclk(pclk),
		.presetn(presetn), .run(run), .line(line), .req_o(cause_in));

	// Clock of 4 ns period.
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	// Counts transfer pulses and cuts a hung run short.
	always @(posedge pclk) begin
		cycles++;
		for (int i = 0; i < NCH; i++) begin
			if (xfer_o[i] === 1'b1) xcnt[i]++;
		end
		if (cycles > 5000) begin
			fails++;
			close_out();
		end
	end

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, msg,
				seen, exp);
		end
	endtask : check

	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) check(32'h0, 32'h1, "no pready");
	endtask : apb

	// Byte address of a register of one channel.
	function automatic logic [11:0] adr(input int ch, input logic [11:0] o);
		return CH_STRIDE * 12'(ch) + o;
	endfunction : adr

	// Register write of one channel.
	task automatic wr(input int ch, input logic [11:0] o,
		input logic [31:0] d);
		apb(1'b1, adr(ch, o), d);
	endtask : wr

	// Register read of one channel, masked, compared.
	task automatic rdc(input int ch, input logic [11:0] o,
		input logic [31:0] exp, input logic [31:0] m, input string msg);
		apb(1'b0, adr(ch, o), 32'h0);
		check(rd & m, exp, msg);
	endtask : rdc

	// Software trigger as a read followed by an OR write.
	// both bits together
	task automatic sw_trig(input int ch);
		apb(1'b0, adr(ch, OFF_CAUSE), 32'h0);
		wr(ch, OFF_CAUSE, rd | 32'h000000a0);
	endtask : sw_trig

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	// Main sequence of scenarios.
	initial begin
		{psel, penable, pwrite, run, presetn} = '0;
		paddr  = '0;
		pwdata = '0;
		line   = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(0, OFF_CAUSE, 32'h0, '1, "cause reset");
		check({31'h0, err}, 32'h0, "mapped no error");
		rdc(0, OFF_MODE, 32'h0, '1, "mode reset");
		apb(1'b0, 12'h020, 32'h0);
		check({31'h0, err}, 32'h1, "unmapped error");
		check(rd, 32'h0, "unmapped data");
		// Full-width writes of the address and count registers.
		for (int i = 0; i < 5; i++) begin
			wr(1, offs[i], 32'hffffffff);
			rdc(1, offs[i], msk[i], '1, "reg readback");
		end
		check(32'(src_o[ADDR_W +: ADDR_W]), 32'hffffff, "src out");
		check(32'(dst_o[ADDR_W +: ADDR_W]), 32'hffffff, "dst out");
		// Trigger on a disabled channel is dropped.
		sw_trig(1);
		repeat (4) @(posedge pclk);
		check(32'(xcnt[1]), 32'h0, "off no xfer");
		rdc(1, OFF_CAUSE, 32'h0, '1, "off flag clear");
		rdc(1, OFF_STATUS, 32'h4, 32'h4, "off drop");
		rdc(1, OFF_CNT, 32'hffff, '1, "off count kept");
		// Trigger on an enabled channel with zero count is dropped.
		wr(2, OFF_CNT, 32'h0);
		wr(2, OFF_MODE, 32'h1);
		sw_trig(2);
		repeat (4) @(posedge pclk);
		check(32'(xcnt[2]), 32'h0, "zero count xfer");
		rdc(2, OFF_CAUSE, 32'h0, '1, "zero count flag");
		rdc(2, OFF_STATUS, 32'h4, 32'h4, "zero count drop");
		// Software start without a cause write, two transfers.
		// short start order
		wr(3, OFF_MODE, 32'h0);
		wr(3, OFF_MEM_RLD, 32'h200);
		wr(3, OFF_MEM, 32'h100);
		wr(3, OFF_CNT_RLD, 32'h2);
		wr(3, OFF_CNT, 32'h2);
		wr(3, OFF_MODE, 32'h1);
		sw_trig(3);
		repeat (4) @(posedge pclk);
		check(32'(xcnt[3]), 32'h1, "sw one xfer");
		rdc(3, OFF_CNT, 32'h1, '1, "count down");
		rdc(3, OFF_MEM, 32'h101, '1, "mem step");
		sw_trig(3);
		repeat (4) @(posedge pclk);
		check(32'(xcnt[3]), 32'h2, "sw two xfer");
		rdc(3, OFF_CNT, 32'h2, '1, "count reload");
		rdc(3, OFF_MEM, 32'h200, '1, "mem reload");
		rdc(3, OFF_MODE, 32'h0, '1, "stopped");
		rdc(3, OFF_STATUS, 32'h2, 32'h2, "done set");
		sw_trig(3);
		repeat (4) @(posedge pclk);
		check(32'(xcnt[3]), 32'h2, "no xfer after done");
		// Timer start with cause write, padding and ordered enables.
		// full start order
		wr(0, OFF_MODE, 32'h0);
		line <= 8'h03;
		wr(0, OFF_CAUSE, 32'h83);
		wr(0, OFF_PERIPH, 32'h55);
		wr(0, OFF_MEM_RLD, 32'h300);
		wr(0, OFF_MEM, 32'h300);
		wr(0, OFF_CNT_RLD, 32'h3);
		wr(0, OFF_CNT, 32'h3);
		repeat (26) @(posedge pclk);
		wr(0, OFF_MODE, 32'h1);
		run <= 1'b1;
		repeat (44) @(posedge pclk);
		run <= 1'b0;
		repeat (4) @(posedge pclk);
		check(32'(xcnt[0]), 32'h3, "timer xfers");
		rdc(0, OFF_CAUSE, 32'h03, '1, "timer cause");
		rdc(0, OFF_STATUS, 32'h6, 32'h6, "done and drop");
		check(32'(src_o[0 +: ADDR_W]), 32'h55, "timer src");
		check(32'(dst_o[0 +: ADDR_W]), 32'h300, "timer dst");
		wr(0, OFF_MODE, 32'h0);
		rdc(0, OFF_STATUS, 32'h0, 32'h6, "sticky cleared");
		close_out();
	end
endmodule : test_dma_request_channel_control
`default_nettype wire
